/* File: rtl/mark_latch_cfg.svh */
// Constants of the mark position latch: command codes, frame lengths,
// field positions and reset values. Assumes inclusion by bare name.
//
// What this block does
// RL1: Capture position on sensor rise and fall separately
// RL2: No capture during home return or manual
// RL3: Capture works in point-table and program methods
// RL4: Command 1A number 00 returns rising value, 8
// RL5: Command 1A number 01 returns falling value, 8
// RL6: Numbers 02, 03 return value plus info, 12
// RL7: Host sends 1A with number selecting edge, format
// RL8: Device answers plain read with captured position
// RL9: Roll feed reports distance from start point
// RL10: Values hold until next edge; reads harmless
`ifndef MARK_LATCH_CFG_SVH
`define MARK_LATCH_CFG_SVH

// ==========================================================
// Command link
`define ML_CMD_READ_LATCH 8'h1A
`define ML_DNO_RISE_PLAIN 8'h00
`define ML_DNO_FALL_PLAIN 8'h01
`define ML_DNO_RISE_EXT   8'h02
`define ML_DNO_FALL_EXT   8'h03
`define ML_LEN_PLAIN      4'h8
`define ML_LEN_EXT        4'hC
`define ML_LEN_NONE       4'h0

// ==========================================================
// Widths and info field layout
`define ML_POS_W          32
`define ML_INFO_W         16
`define ML_INFO_RISE_DONE 0
`define ML_INFO_FALL_DONE 1
`define ML_INFO_ROLL_FEED 2
`define ML_INFO_FALL_SEL  3
`define ML_INFO_ARMED     4

// ==========================================================
// Reset values
`define ML_RST_POS        32'h0000_0000
`define ML_RST_INFO       16'h0000

`endif

/* File: rtl/mark_latch_pkg.sv */
// Types shared by the mark position latch modules.
// Assumes the constants header is compiled alongside.
package mark_latch_pkg;
  // ==========================================================
  // Positioning method reported by the motion controller
  typedef enum logic [1:0] {
    METHOD_POINT_TABLE,
    METHOD_PROGRAM,
    METHOD_OTHER
  } method_t;

  // ==========================================================
  // Command link state
  typedef enum logic {
    ST_IDLE,
    ST_ANSWER
  } link_state_t;

  // ==========================================================
  // Decoded read selection
  typedef struct packed {
    logic ok;
    logic fall;
    logic ext;
  } read_sel_t;
endpackage

/* File: rtl/capture_if.sv */
// Carrier between the latch controller and the edge capture unit.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface capture_if #(parameter int POS_W = 32);
  logic             arm;
  logic [POS_W-1:0] pos;
  logic             rise_evt;
  logic             fall_evt;
  logic [POS_W-1:0] rise_val;
  logic [POS_W-1:0] fall_val;

  modport ctrl (output arm, output pos,
                input rise_evt, input fall_evt, input rise_val, input fall_val);
  modport cap  (input arm, input pos,
                output rise_evt, output fall_evt, output rise_val, output fall_val);
endinterface
`default_nettype wire

/* File: rtl/edge_capture.sv */
// Edge capture unit: synchronises the mark sensor pin and stores the
// offered position on each qualifying edge.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
`include "mark_latch_cfg.svh"
`default_nettype none
module edge_capture (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Sensor pin
  input  wire logic sens_pin,
  // Capture carrier
  capture_if.cap    c
);
  logic                    sync1_r;
  logic                    sync2_r;
  logic                    prev_r;
  logic                    rise_r;
  logic                    fall_r;
  logic [`ML_POS_W-1:0]    rise_val_r;
  logic [`ML_POS_W-1:0]    fall_val_r;
  logic                    rise_nxt;
  logic                    fall_nxt;
  logic [`ML_POS_W-1:0]    rise_val_nxt;
  logic [`ML_POS_W-1:0]    fall_val_nxt;

  // ==========================================================
  // Edge detect and capture
  // The level is tracked while disarmed, so re-arming never fakes an edge
  always_comb begin
    rise_nxt     = c.arm & sync2_r & ~prev_r;                 // [RL1] [RL2]
    fall_nxt     = c.arm & ~sync2_r & prev_r;                 // [RL1] [RL2]
    rise_val_nxt = rise_nxt ? c.pos : rise_val_r;             // [RL1] [RL10]
    fall_val_nxt = fall_nxt ? c.pos : fall_val_r;             // [RL1] [RL10]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r    <= 1'b0;
      sync2_r    <= 1'b0;
      prev_r     <= 1'b0;
      rise_r     <= 1'b0;
      fall_r     <= 1'b0;
      rise_val_r <= `ML_RST_POS;
      fall_val_r <= `ML_RST_POS;
    end else begin
      sync1_r    <= sens_pin;
      sync2_r    <= sync1_r;
      prev_r     <= sync2_r;
      rise_r     <= rise_nxt;
      fall_r     <= fall_nxt;
      rise_val_r <= rise_val_nxt;
      fall_val_r <= fall_val_nxt;
    end
  end

  assign c.rise_evt = rise_r;
  assign c.fall_evt = fall_r;
  assign c.rise_val = rise_val_r;
  assign c.fall_val = fall_val_r;
endmodule
`default_nettype wire

/* File: rtl/mark_position_latch.sv */
// Mark position latch: arms the edge capture unit, keeps latch-complete
// flags and answers read commands on the host command port.
// Assumes ACT_POSITION and the mode inputs come from logic on MCLK.
`timescale 1ns/1ps
`include "mark_latch_cfg.svh"
`default_nettype none
module mark_position_latch #(
  parameter int POS_W  = `ML_POS_W,
  parameter int INFO_W = `ML_INFO_W
) (
  // Clock and reset
  input  wire logic                    MCLK,
  input  wire logic                    RST,
  // Mark sensor pin
  input  wire logic                    MARK_SENSOR_INPUT,
  // Motion state
  input  wire logic [POS_W-1:0]        ACT_POSITION,
  input  wire logic [POS_W-1:0]        START_POSITION,
  input  wire logic                    ROLL_FEED_EN,
  input  wire mark_latch_pkg::method_t POS_METHOD,
  input  wire logic                    HOME_RETURN_BUSY,
  input  wire logic                    MANUAL_OP_BUSY,
  // Command request
  input  wire logic                    CMD_VALID,
  output logic                         CMD_READY,
  input  wire logic [7:0]              CMD_CODE,
  input  wire logic [7:0]              CMD_DATA_NO,
  // Command answer
  output logic                         RSP_VALID,
  output logic                         RSP_ERROR,
  output logic [3:0]                   RSP_LEN,
  output logic [POS_W-1:0]             RSP_DATA,
  output logic [INFO_W-1:0]            RSP_INFO,
  // Latch status
  output logic                         CAPTURE_ARMED,
  output logic                         RISE_LATCHED,
  output logic                         FALL_LATCHED
);

  // ==========================================================
  // Helpers
  // Distance from the start point, wrapping like the position counter
  function automatic logic [POS_W-1:0] feed_pos(input logic [POS_W-1:0] act,
                                                input logic [POS_W-1:0] start,
                                                input logic             roll);
    logic [POS_W-1:0] diff;
    diff = act - start;
    feed_pos = roll ? diff : act;
  endfunction

  // Any unknown code or number is refused rather than guessed
  function automatic mark_latch_pkg::read_sel_t decode(input logic [7:0] code,
                                                       input logic [7:0] dno);
    mark_latch_pkg::read_sel_t s;
    s.ok   = 1'b0;
    s.fall = 1'b0;
    s.ext  = 1'b0;
    if (code == `ML_CMD_READ_LATCH) begin
      case (dno)
        `ML_DNO_RISE_PLAIN: begin
          s.ok = 1'b1;
        end
        `ML_DNO_FALL_PLAIN: begin
          s.ok   = 1'b1;
          s.fall = 1'b1;
        end
        `ML_DNO_RISE_EXT: begin
          s.ok  = 1'b1;
          s.ext = 1'b1;
        end
        `ML_DNO_FALL_EXT: begin
          s.ok   = 1'b1;
          s.fall = 1'b1;
          s.ext  = 1'b1;
        end
        default: begin
          s.ok = 1'b0;
        end
      endcase
    end
    decode = s;
  endfunction

  // ==========================================================
  // Capture arming and edge unit
  capture_if #(.POS_W(POS_W)) cap ();

  logic arm;
  logic method_ok;

  always_comb begin
    method_ok = (POS_METHOD == mark_latch_pkg::METHOD_POINT_TABLE) ||
                (POS_METHOD == mark_latch_pkg::METHOD_PROGRAM);       // [RL3]
    arm       = method_ok & ~HOME_RETURN_BUSY & ~MANUAL_OP_BUSY;     // [RL2]
  end

  assign cap.arm = arm;
  assign cap.pos = feed_pos(ACT_POSITION, START_POSITION, ROLL_FEED_EN); // [RL9]

  edge_capture u_edge (
    .clk      (MCLK),
    .rst      (RST),
    .sens_pin (MARK_SENSOR_INPUT),
    .c        (cap)
  );

  // ==========================================================
  // Latch-complete flags and capture context
  // Edges are one synchroniser apart, so a rise and a fall never coincide
  logic rise_done_r;
  logic fall_done_r;
  logic rise_roll_r;
  logic fall_roll_r;
  logic rise_done_nxt;
  logic fall_done_nxt;
  logic rise_roll_nxt;
  logic fall_roll_nxt;

  always_comb begin
    rise_done_nxt = rise_done_r;
    fall_done_nxt = fall_done_r;
    rise_roll_nxt = rise_roll_r;
    fall_roll_nxt = fall_roll_r;
    if (cap.rise_evt) begin
      rise_done_nxt = 1'b1;                                  // [RL1]
      fall_done_nxt = 1'b0;
      rise_roll_nxt = ROLL_FEED_EN;                          // [RL9]
    end
    if (cap.fall_evt) begin
      fall_done_nxt = 1'b1;                                  // [RL1]
      rise_done_nxt = 1'b0;
      fall_roll_nxt = ROLL_FEED_EN;                          // [RL9]
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rise_done_r <= 1'b0;
      fall_done_r <= 1'b0;
      rise_roll_r <= 1'b0;
      fall_roll_r <= 1'b0;
    end else begin
      rise_done_r <= rise_done_nxt;
      fall_done_r <= fall_done_nxt;
      rise_roll_r <= rise_roll_nxt;
      fall_roll_r <= fall_roll_nxt;
    end
  end

  // ==========================================================
  // Command link
  // One request per two cycles: the answer cycle blocks the next one
  mark_latch_pkg::link_state_t state_r;
  mark_latch_pkg::link_state_t state_nxt;
  mark_latch_pkg::read_sel_t   sel;
  logic                        take;
  logic                        err_r;
  logic                        err_nxt;
  logic [3:0]                  len_r;
  logic [3:0]                  len_nxt;
  logic [POS_W-1:0]            data_r;
  logic [POS_W-1:0]            data_nxt;
  logic [INFO_W-1:0]           info_r;
  logic [INFO_W-1:0]           info_nxt;

  assign CMD_READY = (state_r == mark_latch_pkg::ST_IDLE);
  assign take      = CMD_VALID & CMD_READY;                   // [RL7]

  always_comb begin
    sel       = decode(CMD_CODE, CMD_DATA_NO);                // [RL7]
    state_nxt = state_r;
    err_nxt   = err_r;
    len_nxt   = len_r;
    data_nxt  = data_r;
    info_nxt  = info_r;
    case (state_r)
      mark_latch_pkg::ST_IDLE: begin
        if (take) begin
          state_nxt = mark_latch_pkg::ST_ANSWER;
          err_nxt   = ~sel.ok;
          info_nxt  = `ML_RST_INFO;
          if (!sel.ok) begin
            len_nxt  = `ML_LEN_NONE;
            data_nxt = `ML_RST_POS;
          end else begin
            // Reading only copies; the stored values stay untouched
            data_nxt = sel.fall ? cap.fall_val : cap.rise_val; // [RL8] [RL10]
            len_nxt  = sel.ext ? `ML_LEN_EXT : `ML_LEN_PLAIN;  // [RL4] [RL5] [RL6]
            if (sel.ext) begin
              info_nxt[`ML_INFO_RISE_DONE] = rise_done_r;      // [RL6]
              info_nxt[`ML_INFO_FALL_DONE] = fall_done_r;
              info_nxt[`ML_INFO_ROLL_FEED] = sel.fall ? fall_roll_r : rise_roll_r;
              info_nxt[`ML_INFO_FALL_SEL]  = sel.fall;
              info_nxt[`ML_INFO_ARMED]     = arm;
            end
          end
        end
      end
      mark_latch_pkg::ST_ANSWER: begin
        state_nxt = mark_latch_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = mark_latch_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_r <= mark_latch_pkg::ST_IDLE;
      err_r   <= 1'b0;
      len_r   <= `ML_LEN_NONE;
      data_r  <= `ML_RST_POS;
      info_r  <= `ML_RST_INFO;
    end else begin
      state_r <= state_nxt;
      err_r   <= err_nxt;
      len_r   <= len_nxt;
      data_r  <= data_nxt;
      info_r  <= info_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign RSP_VALID     = (state_r == mark_latch_pkg::ST_ANSWER);
  assign RSP_ERROR     = err_r;
  assign RSP_LEN       = len_r;
  assign RSP_DATA      = data_r;
  assign RSP_INFO      = info_r;
  assign CAPTURE_ARMED = arm;
  assign RISE_LATCHED  = rise_done_r;
  assign FALL_LATCHED  = fall_done_r;

endmodule
`default_nettype wire

/* File: testbench/mark_latch_asserts.sv */
// Checker for the mark position latch top ports.
// Assumes one clock, MCLK, and RST active high.
`timescale 1ns/1ps
`include "mark_latch_cfg.svh"
`default_nettype none
module mark_latch_asserts (
  // Clock and reset
  input wire logic                    MCLK,
  input wire logic                    RST,
  // Watched inputs
  input wire logic                    MARK_SENSOR_INPUT,
  input wire mark_latch_pkg::method_t POS_METHOD,
  input wire logic                    HOME_RETURN_BUSY,
  input wire logic                    MANUAL_OP_BUSY,
  input wire logic                    CMD_VALID,
  input wire logic [7:0]              CMD_CODE,
  input wire logic [7:0]              CMD_DATA_NO,
  // Watched outputs
  input wire logic                    CMD_READY,
  input wire logic                    RSP_VALID,
  input wire logic                    RSP_ERROR,
  input wire logic [3:0]              RSP_LEN,
  input wire logic                    CAPTURE_ARMED,
  input wire logic                    RISE_LATCHED,
  input wire logic                    FALL_LATCHED
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  wire logic take = CMD_VALID && CMD_READY;
  wire logic idle = !HOME_RETURN_BUSY && !MANUAL_OP_BUSY;
  wire logic good = CMD_CODE == `ML_CMD_READ_LATCH && CMD_DATA_NO <= 8'h03;
  // ==========
  // Command port
  a_answer_next: assert property (take |=> RSP_VALID && !CMD_READY)
    else $error("answer missing after take");
  a_answer_pulse: assert property (RSP_VALID |=> !RSP_VALID)
    else $error("answer longer than one cycle");
  a_plain_len: assert property (RSP_VALID && !RSP_ERROR
    && $past(CMD_DATA_NO) < 8'h02 |-> RSP_LEN == `ML_LEN_PLAIN) else $error("plain length wrong");
  a_ext_len: assert property (RSP_VALID && !RSP_ERROR
    && $past(CMD_DATA_NO) > 8'h01 |-> RSP_LEN == `ML_LEN_EXT) else $error("extended length wrong");
  a_unknown_err: assert property (take && !good
    |=> RSP_ERROR && RSP_LEN == `ML_LEN_NONE) else $error("unknown request not refused");
  a_known_ok: assert property (take && good |=> !RSP_ERROR)
    else $error("valid read refused");
  // ==========
  // Capture
  a_busy_disarm: assert property (!idle || POS_METHOD == mark_latch_pkg::METHOD_OTHER
    |-> !CAPTURE_ARMED) else $error("armed while blocked");
  a_method_arm: assert property (idle && POS_METHOD != mark_latch_pkg::METHOD_OTHER
    |-> CAPTURE_ARMED) else $error("not armed in method");
  // Flag rise is seen four edges after the pin sample that caused it
  a_rise_src: assert property ($rose(RISE_LATCHED) |-> $past(MARK_SENSOR_INPUT, 4))
    else $error("rise latch without high pin");
  a_fall_src: assert property ($rose(FALL_LATCHED) |-> !$past(MARK_SENSOR_INPUT, 4))
    else $error("fall latch without low pin");
  a_flags_excl: assert property (!(RISE_LATCHED && FALL_LATCHED))
    else $error("both latch flags set");
  // Flags are seen two edges after the edge detect that used the arm level
  a_no_capture: assert property (!$past(CAPTURE_ARMED, 2)
    |-> $stable(RISE_LATCHED) && $stable(FALL_LATCHED)) else $error("capture while off");
  c_ext: cover property (RSP_VALID && RSP_LEN == `ML_LEN_EXT);
  c_fall: cover property ($rose(FALL_LATCHED));
  c_err: cover property (RSP_VALID && RSP_ERROR);
endmodule
bind mark_position_latch mark_latch_asserts mark_latch_asserts_inst (
  .MCLK(MCLK), .RST(RST), .MARK_SENSOR_INPUT(MARK_SENSOR_INPUT), .POS_METHOD(POS_METHOD),
  .HOME_RETURN_BUSY(HOME_RETURN_BUSY), .MANUAL_OP_BUSY(MANUAL_OP_BUSY),
  .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .CMD_DATA_NO(CMD_DATA_NO),
  .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .RSP_ERROR(RSP_ERROR), .RSP_LEN(RSP_LEN),
  .CAPTURE_ARMED(CAPTURE_ARMED), .RISE_LATCHED(RISE_LATCHED), .FALL_LATCHED(FALL_LATCHED));
`default_nettype wire

/* File: testbench/host_station.sv */
// Host station model on the command port.
// Assumes the port is idle between its own requests.
`timescale 1ns/1ps
`default_nettype none
module host_station (
  // Clock
  input  wire logic      clk,
  // Request
  output var logic       valid,
  output var logic [7:0] code,
  output var logic [7:0] dno
);
  initial begin
    valid = 1'b0;
    code  = 8'h00;
    dno   = 8'h00;
  end
  // ==========
  // One read; returns just after the answer cycle is settled
  task automatic req(input logic [7:0] c, input logic [7:0] d);
    @(posedge clk);
    valid <= 1'b1;
    code  <= c;
    dno   <= d;
    @(posedge clk);
    // Released lines show stale-looking garbage, not the last value
    valid <= 1'b0;
    code  <= ~c;
    dno   <= ~d;
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

/* File: testbench/test_mark_position_latch.sv */
// Self-checking bench for the mark position latch.
// Assumes the host station model drives the command port.
`timescale 1ns/1ps
`include "mark_latch_cfg.svh"
`default_nettype none
module test_mark_position_latch;
  logic        MCLK = 1'b0, RST = 1'b1, MARK_SENSOR_INPUT = 1'b0, ROLL_FEED_EN = 1'b0;
  logic        HOME_RETURN_BUSY = 1'b0, MANUAL_OP_BUSY = 1'b0;
  logic [31:0] ACT_POSITION = 32'h0, START_POSITION = 32'h0;
  mark_latch_pkg::method_t POS_METHOD = mark_latch_pkg::METHOD_POINT_TABLE;
  wire  logic  CMD_VALID, CMD_READY, RSP_VALID, RSP_ERROR, CAPTURE_ARMED, RISE_LATCHED;
  wire  logic  FALL_LATCHED;
  wire  logic [7:0]  CMD_CODE, CMD_DATA_NO;
  wire  logic [3:0]  RSP_LEN;
  wire  logic [31:0] RSP_DATA;
  wire  logic [15:0] RSP_INFO;
  int          error_cnt = 0, n_compared = 0;
  logic [31:0] exp_d [4] = '{32'h1234, 32'h5678, 32'h1234, 32'h5678};
  always #50 MCLK = ~MCLK;
  host_station host_station_inst (.clk(MCLK), .valid(CMD_VALID), .code(CMD_CODE),
    .dno(CMD_DATA_NO));
  mark_position_latch mark_position_latch_inst (.MCLK(MCLK), .RST(RST),
    .MARK_SENSOR_INPUT(MARK_SENSOR_INPUT), .ACT_POSITION(ACT_POSITION),
    .START_POSITION(START_POSITION), .ROLL_FEED_EN(ROLL_FEED_EN), .POS_METHOD(POS_METHOD),
    .HOME_RETURN_BUSY(HOME_RETURN_BUSY), .MANUAL_OP_BUSY(MANUAL_OP_BUSY),
    .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD_CODE(CMD_CODE),
    .CMD_DATA_NO(CMD_DATA_NO), .RSP_VALID(RSP_VALID), .RSP_ERROR(RSP_ERROR),
    .RSP_LEN(RSP_LEN), .RSP_DATA(RSP_DATA), .RSP_INFO(RSP_INFO),
    .CAPTURE_ARMED(CAPTURE_ARMED), .RISE_LATCHED(RISE_LATCHED), .FALL_LATCHED(FALL_LATCHED));
  // ==========
  // Shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] d);
    host_station_inst.req(c, d);
    chk(RSP_VALID, 1'b1);
  endtask
  // Five edges cover the two-stage synchroniser plus capture
  task automatic mark(input logic v, input logic [31:0] p);
    @(posedge MCLK) begin
      MARK_SENSOR_INPUT <= v;
      ACT_POSITION      <= p;
    end
    repeat (5) @(posedge MCLK);
  endtask
  task automatic end_sim;
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_reads;
    mark(1'b1, 32'h1234);
    mark(1'b0, 32'h5678);
    ACT_POSITION <= 32'h9999;
    chk({RISE_LATCHED, FALL_LATCHED}, 2'b01);
    for (int i = 0; i < 4; i++) begin
      rd(`ML_CMD_READ_LATCH, i[7:0]);
      chk(RSP_DATA, exp_d[i]);
      chk(RSP_LEN, (i < 2) ? `ML_LEN_PLAIN : `ML_LEN_EXT);
      chk(RSP_INFO[`ML_INFO_FALL_SEL], (i < 2) ? 1'b0 : i[0]);
      // Extended: armed, fall done, edge select; plain reads carry no info
      chk(RSP_INFO, (i < 2) ? 32'h0 : (i[0] ? 32'h1A : 32'h12));
    end
    rd(`ML_CMD_READ_LATCH, `ML_DNO_RISE_PLAIN);
    chk(RSP_DATA, 32'h1234);
  endtask
  task automatic t_blocked;
    for (int k = 0; k < 3; k++) begin
      @(posedge MCLK) begin
        HOME_RETURN_BUSY <= (k == 0);
        MANUAL_OP_BUSY   <= (k == 1);
        POS_METHOD       <= (k == 2) ? mark_latch_pkg::METHOD_OTHER
                                     : mark_latch_pkg::METHOD_POINT_TABLE;
      end
      mark(1'b1, 32'hAAAA);
      chk(CAPTURE_ARMED, 1'b0);
      mark(1'b0, 32'hBBBB);
      rd(`ML_CMD_READ_LATCH, `ML_DNO_RISE_PLAIN);
      chk(RSP_DATA, 32'h1234);
    end
    @(posedge MCLK) begin
      HOME_RETURN_BUSY <= 1'b0;
      MANUAL_OP_BUSY   <= 1'b0;
      POS_METHOD       <= mark_latch_pkg::METHOD_PROGRAM;
    end
    mark(1'b1, 32'hCCCC);
    rd(`ML_CMD_READ_LATCH, `ML_DNO_RISE_EXT);
    chk(RSP_DATA, 32'hCCCC);
    mark(1'b0, 32'hDDDD);
  endtask
  task automatic t_roll;
    @(posedge MCLK) begin
      ROLL_FEED_EN   <= 1'b1;
      START_POSITION <= 32'h186A0;
    end
    mark(1'b1, 32'h927C0);
    rd(`ML_CMD_READ_LATCH, `ML_DNO_RISE_PLAIN);
    chk(RSP_DATA, 32'h7A120);
    rd(`ML_CMD_READ_LATCH, `ML_DNO_RISE_EXT);
    chk(RSP_DATA, 32'h7A120);
    chk(RSP_INFO, 32'h15);
  endtask
  task automatic t_error;
    rd(8'h1B, `ML_DNO_RISE_PLAIN);
    chk(RSP_ERROR, 1'b1);
    chk(RSP_LEN, `ML_LEN_NONE);
    chk(RSP_DATA, 32'h0);
    rd(`ML_CMD_READ_LATCH, 8'h04);
    chk(RSP_ERROR, 1'b1);
    chk(RSP_LEN, `ML_LEN_NONE);
    chk(RSP_DATA, 32'h0);
    chk(RSP_INFO, 32'h0);
  endtask
  initial begin
    #1000000;
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge MCLK);
    RST <= 1'b0;
    @(negedge MCLK);
    chk({CMD_READY, RSP_LEN, RISE_LATCHED, FALL_LATCHED}, 7'h40);
    t_reads();
    t_blocked();
    t_roll();
    t_error();
    end_sim();
  end
endmodule
`default_nettype wire
